// ### hw/interval_timer_map.svh
// register map, field positions, reset values and timing counts of the interval timer
// assumes inclusion by bare name from the package and the design file
`ifndef INTERVAL_TIMER_MAP_SVH
`define INTERVAL_TIMER_MAP_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define ADDR_TIMER_CONTROL 8'h00
`define ADDR_PERIOD_VALUE 8'h04
`define ADDR_COUNT_VALUE 8'h08
`define ADDR_IRQ_STATUS 8'h0C
`define ADDR_IRQ_MASK 8'h10
`define ADDR_IRQ_PRIORITY 8'h14

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define BIT_RUN_CONTROL 15
`define BIT_IDLE_HALT 13
`define BIT_GATE_ACCUMULATE 6
`define BIT_PRESCALE_HI 5
`define BIT_PRESCALE_LO 4
`define BIT_EXT_SYNC_SELECT 2
`define BIT_CLOCK_SOURCE_SELECT 1
`define CTRL_IMPL_MASK 16'hA076

// ----------------------------------------------------------------
// status bits, reset values, widths, prescale limits
// ----------------------------------------------------------------
`define IRQ_BIT_MATCH 0
`define IRQ_BIT_GATE_FALL 1
`define IRQ_BITS 2
`define PRIO_BITS 3
`define RST_CTRL 16'h0000
`define RST_PERIOD 16'hFFFF
`define RST_ZERO16 16'h0000
`define PRESC_LIM_1 8'h00
`define PRESC_LIM_8 8'h07
`define PRESC_LIM_64 8'h3F
`define PRESC_LIM_256 8'hFF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### hw/interval_timer_pkg.sv
// types shared by the interval timer
// assumes the map header sits beside it
`include "interval_timer_map.svh"

package interval_timer_pkg;
    typedef enum logic [1:0] {
        PRESC_DIV1 = 2'b00,
        PRESC_DIV8 = 2'b01,
        PRESC_DIV64 = 2'b10,
        PRESC_DIV256 = 2'b11
    } prescale_t;

    typedef enum logic [1:0] {
        SRC_INTERNAL = 2'b00,
        SRC_GATED = 2'b01,
        SRC_EXT_SYNC = 2'b10,
        SRC_EXT_ASYNC = 2'b11
    } source_mode_t;
endpackage : interval_timer_pkg

// ### hw/interval_timer.sv
// 16-bit interval timer/counter with prescaler, gate and period match, AXI4-Lite slave
// assumes aclk is the oscillator, pins arrive from outside the clock domain
//
// Contract
// [R01] 16-bit counter runs as timer, synchronous or asynchronous external edge counter
// [R02] interrupt on period match; in gated mode also on gate falling edge
// [R03] run control bit 15 starts counting when 1, stops when 0
// [R04] idle halt bit 13 stops the unit in idle; clear keeps counting
// [R05] gate accumulate bit 6 gates counting only with internal source selected
// [R06] prescale select bits 5-4: 11 by 256, 10 by 64, 01 by 8, 00 by 1
// [R07] ext sync select bit 2 syncs external input; ignored with internal source
// [R08] clock source bit 1: 1 external rising edges, 0 internal at half oscillator
// [R09] control bits 14, 12-7, 3, 0 read zero; implemented bits reset zero
// [R10] control write while running clears the prescale counter; software avoids it
// [R11] software sets run, prescale, source and gating, sync, then the period
// [R12] software sets interrupt enable and three-bit priority when interrupts are wanted
// [R13] counter keeps running in idle or sleep, subject to idle halt; sleep here stops all but the asynchronous external counter
// [R14] each tick increments; at period value next tick returns to zero and flags
// [R15] gated mode advances on internal ticks only while the gate is high
`timescale 1ns/1ps
`include "interval_timer_map.svh"

module interval_timer (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address channel
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address channel
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins and power modes
    input wire logic ext_count_pin,
    input wire logic ext_gate_pin,
    input wire logic idle_mode,
    input wire logic sleep_mode,
    // interrupt
    output logic irq,
    output logic [2:0] match_irq_priority
);

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] d,
                                            input logic [3:0] strb);
        logic [15:0] v;
        v = old_v;
        if (strb[0]) begin
            v[7:0] = d[7:0];
        end
        if (strb[1]) begin
            v[15:8] = d[15:8];
        end
        return v;
    endfunction : merge16

    function automatic logic [7:0] presc_limit(input interval_timer_pkg::prescale_t sel);
        case (sel)
            interval_timer_pkg::PRESC_DIV1: presc_limit = `PRESC_LIM_1;
            interval_timer_pkg::PRESC_DIV8: presc_limit = `PRESC_LIM_8;
            interval_timer_pkg::PRESC_DIV64: presc_limit = `PRESC_LIM_64;
            interval_timer_pkg::PRESC_DIV256: presc_limit = `PRESC_LIM_256;
            default: presc_limit = `PRESC_LIM_1;
        endcase
    endfunction : presc_limit

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [15:0] ctrl_r;
    logic [15:0] period_r;
    logic [15:0] count_r;
    logic [7:0] presc_r;
    logic [`IRQ_BITS-1:0] status_r;
    logic [`IRQ_BITS-1:0] mask_r;
    logic [2:0] prio_r;
    logic pin_s1_r, pin_s2_r, pin_s3_r;
    logic gate_s1_r, gate_s2_r, gate_s3_r;
    logic half_en_r;
    logic pend_r;
    logic aw_held_r, w_held_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic [1:0] bresp_r;
    logic bvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic rvalid_r;

    // ----------------------------------------------------------------
    // control decode
    // ----------------------------------------------------------------
    logic run_control, idle_halt, gate_accumulate, ext_sync_select, clock_source_select;
    interval_timer_pkg::prescale_t prescale_select;
    interval_timer_pkg::source_mode_t src_mode;
    logic [7:0] presc_lim;

    assign run_control = ctrl_r[`BIT_RUN_CONTROL];
    assign idle_halt = ctrl_r[`BIT_IDLE_HALT];
    assign gate_accumulate = ctrl_r[`BIT_GATE_ACCUMULATE];
    assign ext_sync_select = ctrl_r[`BIT_EXT_SYNC_SELECT];
    assign clock_source_select = ctrl_r[`BIT_CLOCK_SOURCE_SELECT];
    assign prescale_select =
        interval_timer_pkg::prescale_t'(ctrl_r[`BIT_PRESCALE_HI:`BIT_PRESCALE_LO]);
    assign presc_lim = presc_limit(prescale_select);

    always_comb begin
        if (clock_source_select) begin
            src_mode = ext_sync_select ? interval_timer_pkg::SRC_EXT_SYNC
                                       : interval_timer_pkg::SRC_EXT_ASYNC; // see [R07]
        end else begin
            src_mode = gate_accumulate ? interval_timer_pkg::SRC_GATED
                                       : interval_timer_pkg::SRC_INTERNAL; // see [R05]
        end
    end

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    logic wr_fire, rd_fire, wr_ok, rd_ok;
    logic wr_ctrl, wr_period, wr_count, wr_status, wr_mask, wr_prio;
    logic [15:0] ctrl_new;

    assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
    assign rd_fire = s_axi_arvalid && !rvalid_r;
    assign wr_ctrl = wr_fire && awaddr_r == `ADDR_TIMER_CONTROL;
    assign wr_period = wr_fire && awaddr_r == `ADDR_PERIOD_VALUE;
    assign wr_count = wr_fire && awaddr_r == `ADDR_COUNT_VALUE;
    assign wr_status = wr_fire && awaddr_r == `ADDR_IRQ_STATUS;
    assign wr_mask = wr_fire && awaddr_r == `ADDR_IRQ_MASK;
    assign wr_prio = wr_fire && awaddr_r == `ADDR_IRQ_PRIORITY;
    assign wr_ok = wr_ctrl || wr_period || wr_count || wr_status || wr_mask || wr_prio;
    assign ctrl_new = merge16(ctrl_r, wdata_r, wstrb_r) & `CTRL_IMPL_MASK; // see [R09]

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
            pin_s3_r <= 1'b0;
            gate_s1_r <= 1'b0;
            gate_s2_r <= 1'b0;
            gate_s3_r <= 1'b0;
        end else begin
            pin_s1_r <= ext_count_pin;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            gate_s1_r <= ext_gate_pin;
            gate_s2_r <= gate_s1_r;
            gate_s3_r <= gate_s2_r;
        end
    end

    // ----------------------------------------------------------------
    // count source and enables
    // ----------------------------------------------------------------
    logic ext_rise, gate_fall, src_en, run_en, tick;

    assign ext_rise = pin_s2_r && !pin_s3_r;
    assign gate_fall = gate_s3_r && !gate_s2_r;

    always_comb begin
        case (src_mode)
            interval_timer_pkg::SRC_INTERNAL: src_en = half_en_r; // see [R08]
            interval_timer_pkg::SRC_GATED: src_en = half_en_r && gate_s2_r; // see [R15]
            interval_timer_pkg::SRC_EXT_SYNC: src_en = pend_r && half_en_r; // see [R07]
            interval_timer_pkg::SRC_EXT_ASYNC: src_en = ext_rise; // see [R01]
            default: src_en = 1'b0;
        endcase
    end

    // sleep stops the internal clock; only the unsynchronised counter keeps going
    assign run_en = run_control // see [R03]
        && !(idle_mode && idle_halt) // see [R04]
        && !(sleep_mode && src_mode != interval_timer_pkg::SRC_EXT_ASYNC); // see [R13]
    assign tick = run_en && src_en && presc_r == presc_lim;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            half_en_r <= 1'b0;
        end else begin
            half_en_r <= !half_en_r; // see [R08]
        end
    end

    // external edge held until the next internal clock phase
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_r <= 1'b0;
        end else if (ext_rise) begin
            pend_r <= 1'b1;
        end else if (half_en_r) begin
            pend_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // prescaler and counter
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            presc_r <= 8'h00;
        end else if ((wr_ctrl && run_control) || !run_control) begin
            presc_r <= 8'h00; // see [R10]
        end else if (run_en && src_en) begin
            presc_r <= (presc_r == presc_lim) ? 8'h00 : presc_r + 8'h01; // see [R06]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_r <= `RST_ZERO16;
        end else if (wr_count) begin
            count_r <= merge16(count_r, wdata_r, wstrb_r);
        end else if (tick) begin
            count_r <= (count_r == period_r) ? `RST_ZERO16 : count_r + 16'h0001; // see [R14]
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= `RST_CTRL; // see [R09]
        end else if (wr_ctrl) begin
            ctrl_r <= ctrl_new;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_r <= `RST_PERIOD;
            mask_r <= '0;
            prio_r <= 3'h0;
        end else begin
            if (wr_period) begin
                period_r <= merge16(period_r, wdata_r, wstrb_r);
            end
            if (wr_mask && wstrb_r[0]) begin
                mask_r <= wdata_r[`IRQ_BITS-1:0];
            end
            if (wr_prio && wstrb_r[0]) begin
                prio_r <= wdata_r[`PRIO_BITS-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupt status, set wins over clear
    // ----------------------------------------------------------------
    logic [`IRQ_BITS-1:0] irq_set, irq_clr;

    always_comb begin
        irq_set = '0;
        irq_set[`IRQ_BIT_MATCH] = tick && count_r == period_r; // see [R02]
        irq_set[`IRQ_BIT_GATE_FALL] = run_en
            && src_mode == interval_timer_pkg::SRC_GATED && gate_fall; // see [R02]
        irq_clr = (wr_status && wstrb_r[0]) ? wdata_r[`IRQ_BITS-1:0] : '0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_r <= '0;
        end else begin
            status_r <= (status_r & ~irq_clr) | irq_set;
        end
    end

    assign irq = |(status_r & mask_r);
    assign match_irq_priority = prio_r;

    // ----------------------------------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= `RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    assign s_axi_awready = !aw_held_r;
    assign s_axi_wready = !w_held_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // ----------------------------------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------------------------------
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `ADDR_TIMER_CONTROL: rd_mux[15:0] = ctrl_r;
            `ADDR_PERIOD_VALUE: rd_mux[15:0] = period_r;
            `ADDR_COUNT_VALUE: rd_mux[15:0] = count_r;
            `ADDR_IRQ_STATUS: rd_mux[`IRQ_BITS-1:0] = status_r;
            `ADDR_IRQ_MASK: rd_mux[`IRQ_BITS-1:0] = mask_r;
            `ADDR_IRQ_PRIORITY: rd_mux[`PRIO_BITS-1:0] = prio_r;
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_wrap;
        tick && count_r == period_r && !wr_count;
    endsequence

    sequence s_ctrl_write_running;
        wr_ctrl && run_control;
    endsequence

    property p_reserved_zero;
        @(posedge aclk) disable iff (!aresetn)
        (ctrl_r & ~`CTRL_IMPL_MASK) == 16'h0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // see [R09]
        else $error("unimplemented control bit set");

    property p_match_wrap;
        @(posedge aclk) disable iff (!aresetn)
        s_wrap |=> count_r == 16'h0000 && status_r[`IRQ_BIT_MATCH];
    endproperty
    a_match_wrap: assert property (p_match_wrap) // see [R14]
        else $error("period match did not wrap and flag");

    property p_stopped;
        @(posedge aclk) disable iff (!aresetn)
        !run_control && !wr_count |=> $stable(count_r);
    endproperty
    a_stopped: assert property (p_stopped) // see [R03]
        else $error("count moved while stopped");

    property p_idle_halt;
        @(posedge aclk) disable iff (!aresetn)
        idle_mode && idle_halt && !wr_count |=> $stable(count_r);
    endproperty
    a_idle_halt: assert property (p_idle_halt) // see [R04]
        else $error("count moved in idle with halt set");

    property p_presc_clear;
        @(posedge aclk) disable iff (!aresetn)
        s_ctrl_write_running |=> presc_r == 8'h00;
    endproperty
    a_presc_clear: assert property (p_presc_clear) // see [R10]
        else $error("prescaler not cleared by control write");

    property p_gate_block;
        @(posedge aclk) disable iff (!aresetn)
        !clock_source_select && gate_accumulate && !gate_s2_r |-> !tick;
    endproperty
    a_gate_block: assert property (p_gate_block) // see [R15]
        else $error("tick while gate low");

    property p_gate_fall_irq;
        @(posedge aclk) disable iff (!aresetn)
        run_en && src_mode == interval_timer_pkg::SRC_GATED && gate_fall
            |=> status_r[`IRQ_BIT_GATE_FALL] ##0 (irq == mask_r[`IRQ_BIT_GATE_FALL]
            || status_r[`IRQ_BIT_MATCH]);
    endproperty
    a_gate_fall_irq: assert property (p_gate_fall_irq) // see [R02]
        else $error("gate falling edge not flagged");

    property p_half_rate;
        @(posedge aclk) disable iff (!aresetn)
        tick && src_mode == interval_timer_pkg::SRC_INTERNAL |=> !tick;
    endproperty
    a_half_rate: assert property (p_half_rate) // see [R08]
        else $error("internal source faster than half rate");

    property p_async_edge;
        @(posedge aclk) disable iff (!aresetn)
        src_mode == interval_timer_pkg::SRC_EXT_ASYNC && run_en
            && prescale_select == interval_timer_pkg::PRESC_DIV1 && ext_rise |-> tick;
    endproperty
    a_async_edge: assert property (p_async_edge) // see [R01]
        else $error("external edge not counted");

    property p_div8;
        @(posedge aclk) disable iff (!aresetn)
        tick && prescale_select == interval_timer_pkg::PRESC_DIV8 |-> presc_r == `PRESC_LIM_8;
    endproperty
    a_div8: assert property (p_div8) // see [R06]
        else $error("divide by eight tick at wrong count");

    property p_sleep_sync;
        @(posedge aclk) disable iff (!aresetn)
        sleep_mode && src_mode != interval_timer_pkg::SRC_EXT_ASYNC |-> !tick;
    endproperty
    a_sleep_sync: assert property (p_sleep_sync) // see [R13]
        else $error("clocked count advanced in sleep");

endmodule : interval_timer

// ### tb/ext_source.sv
// partner model: external count pin and gate sources of the timer
// assumes the caller enters its tasks just after a clock edge
`timescale 1ns/1ps

module ext_source (
    // pins toward the timer
    output logic count_pin,
    output logic gate_pin
);
    // idle low outside bursts
    initial begin
        count_pin = 1'b0;
        gate_pin = 1'b0;
    end

    // n rising edges, half period in ns, fast or slow
    task automatic pulse(input int n, input int half);
        #1;
        repeat (n) begin
            count_pin = 1'b1;
            #(half);
            count_pin = 1'b0;
            #(half);
        end
    endtask : pulse

    // gate level, off the clock edge
    task automatic set_gate(input logic lv);
        #1;
        gate_pin = lv;
    endtask : set_gate
endmodule : ext_source

// ### tb/tb.sv
// self-checking bench of the interval timer
// assumes the map header and the partner model beside it
`timescale 1ns/1ps
`include "interval_timer_map.svh"

module tb;
    logic aclk, aresetn, awv, wv, br, arv, rr, idle, slp;
    logic awr, wrdy, bv, arr, rv, pin, gate, irq;
    logic [7:0] awa, ara;
    logic [31:0] wd, rd, v;
    logic [1:0] bresp, rresp, resp;
    logic [2:0] prio;
    logic [3:0] ws;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    int d[4] = '{1, 8, 64, 256};

    interval_timer interval_timer_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .ext_count_pin(pin), .ext_gate_pin(gate), .idle_mode(idle),
        .sleep_mode(slp), .irq(irq), .match_irq_priority(prio));
    ext_source ext_source_inst (.count_pin(pin), .gate_pin(gate));

    // ----------------------------------------
    // clock, timeout, report
    // ----------------------------------------
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // ----------------------------------------
    // bus cycles
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        @(posedge aclk);
        awa <= a;
        wd <= dat;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wrdy) wv <= 1'b0;
            if (bv) begin
                resp = bresp;
                br <= 1'b0;
                break;
            end
        end
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arv && arr) arv <= 1'b0;
            if (rv) begin
                v = rd;
                resp = rresp;
                rr <= 1'b0;
                break;
            end
        end
    endtask : rdr

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        rdr(`ADDR_TIMER_CONTROL);
        chk(v, 32'h0);
        rdr(`ADDR_PERIOD_VALUE);
        chk(v, 32'hFFFF);
        rdr(`ADDR_COUNT_VALUE);
        chk(v, 32'h0);
        ws <= 4'h1;
        wr(`ADDR_PERIOD_VALUE, 32'h1234);
        ws <= 4'hF;
        rdr(`ADDR_PERIOD_VALUE);
        chk(v, 32'hFF34);
        wr(`ADDR_TIMER_CONTROL, 32'hFFFFFFFF);
        rdr(`ADDR_TIMER_CONTROL);
        chk(v, 32'hA076);
        wr(`ADDR_TIMER_CONTROL, 32'h0);
        wr(8'h40, 32'h1);
        chk(32'(resp), 32'h2);
        rdr(8'h40);
        chk(v, 32'h0);
        chk(32'(resp), 32'h2);
        wr(`ADDR_IRQ_PRIORITY, 32'h5);
        chk(32'(prio), 32'h5);
    endtask : t_regs

    task automatic t_prescale();
        for (int i = 0; i < 4; i++) begin
            wr(`ADDR_COUNT_VALUE, 32'h0);
            wr(`ADDR_TIMER_CONTROL, 32'h8000 | (32'(i) << 4));
            repeat (32 * d[i]) @(posedge aclk);
            wr(`ADDR_TIMER_CONTROL, 32'h0);
            rdr(`ADDR_COUNT_VALUE);
            chk(32'(v >= 14 && v <= 18), 32'h1);
        end
        repeat (20) @(posedge aclk);
        rdr(`ADDR_COUNT_VALUE);
        chk(32'(v >= 14 && v <= 18), 32'h1);
    endtask : t_prescale

    task automatic t_clear();
        wr(`ADDR_COUNT_VALUE, 32'h0);
        wr(`ADDR_TIMER_CONTROL, 32'h8030);
        repeat (200) @(posedge aclk);
        wr(`ADDR_TIMER_CONTROL, 32'h8030);
        repeat (400) @(posedge aclk);
        wr(`ADDR_TIMER_CONTROL, 32'h0);
        rdr(`ADDR_COUNT_VALUE);
        chk(v, 32'h0);
    endtask : t_clear

    task automatic t_match();
        wr(`ADDR_COUNT_VALUE, 32'h0);
        wr(`ADDR_TIMER_CONTROL, 32'h8000);
        wr(`ADDR_PERIOD_VALUE, 32'h4);
        repeat (40) @(posedge aclk);
        wr(`ADDR_TIMER_CONTROL, 32'h0);
        rdr(`ADDR_COUNT_VALUE);
        chk(32'(v <= 4), 32'h1);
        rdr(`ADDR_IRQ_STATUS);
        chk(v, 32'h1);
        chk(32'(irq), 32'h0);
        wr(`ADDR_IRQ_MASK, 32'h3);
        @(posedge aclk);
        chk(32'(irq), 32'h1);
        wr(`ADDR_IRQ_STATUS, 32'h1);
        rdr(`ADDR_IRQ_STATUS);
        chk(v, 32'h0);
        chk(32'(irq), 32'h0);
        wr(`ADDR_PERIOD_VALUE, 32'hFFFF);
    endtask : t_match

    task automatic t_ext();
        for (int s = 0; s < 2; s++) begin
            wr(`ADDR_COUNT_VALUE, 32'h0);
            wr(`ADDR_TIMER_CONTROL, 32'h8042 | (32'(s) << 2));
            ext_source_inst.pulse(5, 8 + 8 * s);
            repeat (10) @(posedge aclk);
            wr(`ADDR_TIMER_CONTROL, 32'h0);
            rdr(`ADDR_COUNT_VALUE);
            chk(v, 32'h5);
        end
    endtask : t_ext

    task automatic t_gate();
        wr(`ADDR_COUNT_VALUE, 32'h0);
        wr(`ADDR_TIMER_CONTROL, 32'h8040);
        repeat (40) @(posedge aclk);
        rdr(`ADDR_COUNT_VALUE);
        chk(v, 32'h0);
        ext_source_inst.set_gate(1'b1);
        repeat (40) @(posedge aclk);
        ext_source_inst.set_gate(1'b0);
        repeat (10) @(posedge aclk);
        wr(`ADDR_TIMER_CONTROL, 32'h0);
        rdr(`ADDR_COUNT_VALUE);
        chk(32'(v >= 16 && v <= 24), 32'h1);
        rdr(`ADDR_IRQ_STATUS);
        chk(v, 32'h2);
        wr(`ADDR_IRQ_STATUS, 32'h3);
    endtask : t_gate

    task automatic t_idle();
        idle <= 1'b1;
        wr(`ADDR_COUNT_VALUE, 32'h0);
        wr(`ADDR_TIMER_CONTROL, 32'hA000);
        repeat (40) @(posedge aclk);
        rdr(`ADDR_COUNT_VALUE);
        chk(v, 32'h0);
        wr(`ADDR_TIMER_CONTROL, 32'h8000);
        repeat (40) @(posedge aclk);
        wr(`ADDR_TIMER_CONTROL, 32'h0);
        rdr(`ADDR_COUNT_VALUE);
        chk(32'(v >= 18 && v <= 26), 32'h1);
        idle <= 1'b0;
    endtask : t_idle

    // sleep: only the unsynchronised counter keeps going
    task automatic t_sleep();
        slp <= 1'b1;
        for (int s = 0; s < 2; s++) begin
            wr(`ADDR_COUNT_VALUE, 32'h0);
            wr(`ADDR_TIMER_CONTROL, 32'h8002 | (32'(s) << 2));
            ext_source_inst.pulse(3, 8);
            repeat (10) @(posedge aclk);
            rdr(`ADDR_COUNT_VALUE);
            chk(v, s ? 32'h0 : 32'h3);
        end
        wr(`ADDR_TIMER_CONTROL, 32'h0);
        slp <= 1'b0;
    endtask : t_sleep

    initial begin
        {awv, wv, br, arv, rr, idle, slp, aresetn} = '0;
        ws = 4'hF;
        awa = '0;
        ara = '0;
        wd = '0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_prescale();
        t_clear();
        t_match();
        t_ext();
        t_gate();
        t_idle();
        t_sleep();
        final_report();
    end
endmodule : tb
